/* File: flash_suspend_command_gate.sv */
`timescale 1ns/1ps

// ============================================================================
// Behaviour
// - program or erase byte failure sets write or wipe fault flag.
// - opcodes 75h and B0h both suspend, identically.
// - suspend is opcode only; no address or data expected.
// - suspension starts only at chip select release after the opcode.
// - running program or erase can be halted for other operations.
// - opcode not permitted in current state is discarded, no action.
// - a rejected opcode leaves the write latch untouched.
// - state from busy, write-halted and wipe-halted flags.
// - while busy only suspend, status, terminate, reset, id, wake pass.
// - when suspended also reads, resume, latch and setup commands pass.
// - suspend is rejected when already suspended and not busy.
// - in erase suspend, programs pass only outside the halted 64 kB block.
// - erases, locks, otp program, status writes, power-down rejected while busy or suspended.
// - on halt set paused flag and matching halted flag, clear busy.
// - suspend ignored while an unsuspendable operation runs.
// - suspend acts regardless of the write latch.
// - release acts only after whole opcode on a byte boundary; cut mid-byte it is rejected, short of 8 bits nothing.
module flash_suspend_command_gate (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          sclk_i,
  input  wire logic                          cs_n_i,
  input  wire logic                          si_i,
  input  wire logic                          op_start_i,
  input  wire flash_gate_pkg::op_kind_e      op_kind_i,
  input  wire logic [flash_gate_pkg::BLOCK_W-1:0] op_block_i,
  input  wire logic                          op_done_i,
  input  wire logic                          suspend_done_i,
  input  wire logic                          resume_i,
  input  wire logic                          prog_fault_i,
  input  wire logic                          erase_fault_i,
  input  wire logic                          fault_clear_i,
  output logic                               cmd_valid_o,
  output logic [flash_gate_pkg::OP_W-1:0]    cmd_opcode_o,
  output logic                               cmd_reject_o,
  output logic                               suspend_req_o,
  output logic                               busy_flag_o,
  output logic                               write_halted_flag_o,
  output logic                               wipe_halted_flag_o,
  output logic                               paused_op_flag_o,
  output logic                               write_latch_o,
  output logic                               write_fault_flag_o,
  output logic                               wipe_fault_flag_o
);
  import flash_gate_pkg::*;

  localparam int SYNC_W = 3 + 1 + OP_W + BLOCK_W;

  // ==========================================================================
  // permission table
  function automatic cmd_class_e classify(input logic [OP_W-1:0] op);
    cmd_class_e cls;
    cls = CL_NEVER;
    case (op)
      OP_SUSPEND_LEGACY, OP_SUSPEND_NEW: begin
        cls = CL_SUSPEND;
      end
      8'h05, 8'h35, 8'h15, 8'h65,
      8'hF0, 8'h66, 8'h99,
      8'h9F, 8'h90, 8'h94,
      8'hAB: begin
        cls = CL_ANY;
      end
      8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'hE7,
      8'hD0, 8'h7A,
      OP_WRITE_ENABLE, OP_WRITE_DISABLE, 8'h50,
      8'h3C, 8'h3D, 8'h4B, 8'h5A, 8'h77: begin
        cls = CL_PAUSED;
      end
      8'h02, 8'hA2, 8'h32, 8'hAD, 8'hAF: begin
        cls = CL_ERASE_PAUSED;
      end
      default: begin
        cls = CL_NEVER;
      end
    endcase
    return cls;
  endfunction : classify

  function automatic logic permitted(input cmd_class_e cls,
                                     input logic busy,
                                     input logic ps,
                                     input logic es);
    logic ok;
    ok = 1'b1;
    if (busy) begin
      ok = (cls == CL_ANY) || (cls == CL_SUSPEND);
    end else if (ps) begin
      ok = (cls == CL_ANY) || (cls == CL_PAUSED);
    end else if (es) begin
      ok = (cls == CL_ANY) || (cls == CL_PAUSED) || (cls == CL_ERASE_PAUSED);
    end
    return ok;
  endfunction : permitted

  function automatic logic is_suspend(input logic [OP_W-1:0] op);
    return (op == OP_SUSPEND_LEGACY) || (op == OP_SUSPEND_NEW);
  endfunction : is_suspend

  // ==========================================================================
  // link side and crossing
  logic [OP_W-1:0]    link_opcode;
  logic               link_op_tog;
  logic [BLOCK_W-1:0] link_block;
  logic               link_blk_tog;
  logic               link_mid;
  logic [SYNC_W-1:0]  sync_in;
  logic [SYNC_W-1:0]  sync_out;

  spi_link_rx u_link (
    .sclk_i     (sclk_i),
    .cs_n_i     (cs_n_i),
    .reset_n_i  (reset_n_i),
    .si_i       (si_i),
    .opcode_o   (link_opcode),
    .op_tog_o   (link_op_tog),
    .block_o    (link_block),
    .blk_tog_o  (link_blk_tog),
    .mid_byte_o (link_mid)
  );

  assign sync_in = {cs_n_i, link_op_tog, link_blk_tog, link_mid, link_opcode, link_block};

  sync_2ff #(
    .W (SYNC_W)
  ) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .d_i       (sync_in),
    .q_o       (sync_out)
  );

  logic               cs_s;
  logic               op_tog_s;
  logic               blk_tog_s;
  logic               mid_s;
  logic [OP_W-1:0]    opcode_s;
  logic [BLOCK_W-1:0] block_s;

  assign cs_s      = sync_out[SYNC_W-1];
  assign op_tog_s  = sync_out[SYNC_W-2];
  assign blk_tog_s = sync_out[SYNC_W-3];
  assign mid_s     = sync_out[SYNC_W-4];
  assign opcode_s  = sync_out[OP_W+BLOCK_W-1:BLOCK_W];
  assign block_s   = sync_out[BLOCK_W-1:0];

  // ==========================================================================
  // edge detection; words read one cycle after the toggle so they have settled
  logic cs_d_q;
  logic op_tog_d_q;
  logic blk_tog_d_q;
  logic op_take_q;
  logic blk_take_q;
  logic end_q;
  logic end_qq;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_d_q      <= FLAG_RESET;
      op_tog_d_q  <= TOG_RESET;
      blk_tog_d_q <= TOG_RESET;
      op_take_q   <= FLAG_RESET;
      blk_take_q  <= FLAG_RESET;
      end_q       <= FLAG_RESET;
      end_qq      <= FLAG_RESET;
    end else begin
      cs_d_q      <= cs_s;
      op_tog_d_q  <= op_tog_s;
      blk_tog_d_q <= blk_tog_s;
      op_take_q   <= op_tog_s ^ op_tog_d_q;
      blk_take_q  <= blk_tog_s ^ blk_tog_d_q;
      // frame end delayed so the last opcode is always judged first
      end_q       <= cs_s && !cs_d_q;
      end_qq      <= end_q;
    end
  end

  // ==========================================================================
  // flags
  logic               busy_q;
  logic               ps_q;
  logic               es_q;
  logic               sus_wait_q;
  op_kind_e           run_kind_q;
  logic [BLOCK_W-1:0] run_block_q;
  logic [BLOCK_W-1:0] wipe_block_q;
  logic               ps_d;
  logic               es_d;

  always_comb begin
    ps_d = ps_q;
    es_d = es_q;
    if (suspend_done_i && sus_wait_q) begin
      ps_d = ps_q || (run_kind_q == OPK_PROGRAM);
      es_d = es_q || (run_kind_q == OPK_ERASE);
    end else if (resume_i) begin
      // nested program resumes ahead of the halted erase
      if (ps_q) begin
        ps_d = 1'b0;
      end else begin
        es_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q           <= FLAG_RESET;
      ps_q             <= FLAG_RESET;
      es_q             <= FLAG_RESET;
      paused_op_flag_o <= FLAG_RESET;
    end else begin
      ps_q             <= ps_d;
      es_q             <= es_d;
      paused_op_flag_o <= ps_d || es_d;
      if (op_start_i || resume_i) begin
        busy_q <= 1'b1;
      end else if (op_done_i || (suspend_done_i && sus_wait_q)) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_kind_q   <= OPK_FIXED;
      run_block_q  <= BLOCK_RESET;
      wipe_block_q <= BLOCK_RESET;
    end else begin
      if (op_start_i) begin
        run_kind_q  <= op_kind_i;
        run_block_q <= op_block_i;
      end
      if (suspend_done_i && sus_wait_q && run_kind_q == OPK_ERASE) begin
        wipe_block_q <= run_block_q;
      end
    end
  end

  // ==========================================================================
  // fault flags, a new fault wins over a clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_fault_flag_o <= FLAG_RESET;
      wipe_fault_flag_o  <= FLAG_RESET;
    end else begin
      if (prog_fault_i) begin
        write_fault_flag_o <= 1'b1;
      end else if (fault_clear_i) begin
        write_fault_flag_o <= 1'b0;
      end
      if (erase_fault_i) begin
        wipe_fault_flag_o <= 1'b1;
      end else if (fault_clear_i) begin
        wipe_fault_flag_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // per-frame verdict, taken at the eighth bit
  logic               have_op_q;
  logic               allow_q;
  logic               need_blk_q;
  logic               got_blk_q;
  logic [OP_W-1:0]    op_q;
  logic [BLOCK_W-1:0] blk_q;
  cmd_class_e         cls;

  assign cls = classify(opcode_s);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      have_op_q  <= FLAG_RESET;
      allow_q    <= FLAG_RESET;
      need_blk_q <= FLAG_RESET;
      got_blk_q  <= FLAG_RESET;
      op_q       <= OP_RESET;
      blk_q      <= BLOCK_RESET;
    end else if (end_qq) begin
      have_op_q <= 1'b0;
      got_blk_q <= 1'b0;
    end else begin
      if (op_take_q) begin
        have_op_q  <= 1'b1;
        op_q       <= opcode_s;
        allow_q    <= permitted(cls, busy_q, ps_q, es_q);
        need_blk_q <= (cls == CL_ERASE_PAUSED) && !busy_q && !ps_q && es_q;
      end
      if (blk_take_q) begin
        got_blk_q <= 1'b1;
        blk_q     <= block_s;
      end
    end
  end

  // ==========================================================================
  // action at chip select release
  logic whole;
  logic blk_ok;
  logic sus_ok;
  logic accept;

  assign whole  = have_op_q && !mid_s;
  assign blk_ok = !need_blk_q || (got_blk_q && blk_q != wipe_block_q);
  assign sus_ok = !is_suspend(op_q) ||
                  (busy_q && run_kind_q != OPK_FIXED && !sus_wait_q);
  assign accept = whole && allow_q && blk_ok && sus_ok;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_valid_o   <= FLAG_RESET;
      cmd_reject_o  <= FLAG_RESET;
      suspend_req_o <= FLAG_RESET;
      cmd_opcode_o  <= OP_RESET;
    end else begin
      cmd_valid_o   <= end_qq && accept;
      cmd_reject_o  <= end_qq && have_op_q && !accept;
      suspend_req_o <= end_qq && accept && is_suspend(op_q);
      if (end_qq && have_op_q) begin
        cmd_opcode_o <= op_q;
      end
    end
  end

  // suspend waits for the array to report the halt
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sus_wait_q <= FLAG_RESET;
    end else if (end_qq && accept && is_suspend(op_q)) begin
      sus_wait_q <= 1'b1;
    end else if (suspend_done_i || op_done_i) begin
      sus_wait_q <= 1'b0;
    end
  end

  // ==========================================================================
  // write latch, moved only by accepted commands
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      write_latch_o <= FLAG_RESET;
    end else if (end_qq && accept) begin
      if (op_q == OP_WRITE_ENABLE) begin
        write_latch_o <= 1'b1;
      end else if (op_q == OP_WRITE_DISABLE) begin
        write_latch_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // flag outputs
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_flag_o         <= FLAG_RESET;
      write_halted_flag_o <= FLAG_RESET;
      wipe_halted_flag_o  <= FLAG_RESET;
    end else begin
      busy_flag_o         <= busy_q;
      write_halted_flag_o <= ps_q;
      wipe_halted_flag_o  <= es_q;
    end
  end

endmodule : flash_suspend_command_gate

/* File: flash_gate_pkg.sv */
package flash_gate_pkg;

  // ==========================================================================
  // widths
  localparam int OP_W    = 8;
  localparam int BLOCK_W = 8;
  localparam int PHASE_W = 3;
  localparam int BYTE_W  = 2;

  // ==========================================================================
  // frame positions, counted on the serial clock
  localparam logic [PHASE_W-1:0] PHASE_LAST  = 3'h7;
  localparam logic [BYTE_W-1:0]  BYTE_OPCODE = 2'h0;
  localparam logic [BYTE_W-1:0]  BYTE_BLOCK  = 2'h1;
  localparam logic [BYTE_W-1:0]  BYTE_SAT    = 2'h3;

  // ==========================================================================
  // opcodes steering the gate itself
  localparam logic [OP_W-1:0] OP_SUSPEND_LEGACY = 8'h75;
  localparam logic [OP_W-1:0] OP_SUSPEND_NEW    = 8'hB0;
  localparam logic [OP_W-1:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [OP_W-1:0] OP_WRITE_DISABLE  = 8'h04;

  // ==========================================================================
  // reset values
  localparam logic              FLAG_RESET  = 1'b0;
  localparam logic              TOG_RESET   = 1'b0;
  localparam logic [OP_W-1:0]   OP_RESET    = 8'h00;
  localparam logic [BLOCK_W-1:0] BLOCK_RESET = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    CL_ANY,
    CL_SUSPEND,
    CL_PAUSED,
    CL_ERASE_PAUSED,
    CL_NEVER
  } cmd_class_e;

  typedef enum logic [1:0] {
    OPK_PROGRAM,
    OPK_ERASE,
    OPK_FIXED
  } op_kind_e;

endpackage : flash_gate_pkg

/* File: sync_2ff.sv */
`timescale 1ns/1ps

// ============================================================================
// two-stage synchroniser, first stage read by the second only
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : sync_2ff

/* File: spi_link_rx.sv */
`timescale 1ns/1ps

// ============================================================================
// serial receive on the link clock; words held stable, announced by toggles
module spi_link_rx
  import flash_gate_pkg::*;
(
  input  wire logic                         sclk_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         si_i,
  output logic [flash_gate_pkg::OP_W-1:0]    opcode_o,
  output logic                              op_tog_o,
  output logic [flash_gate_pkg::BLOCK_W-1:0] block_o,
  output logic                              blk_tog_o,
  output logic                              mid_byte_o
);
  logic [PHASE_W-1:0] phase_q;
  logic [BYTE_W-1:0]  byte_q;
  logic [OP_W-2:0]    shift_q;
  logic               byte_end;

  assign byte_end = (phase_q == PHASE_LAST);

  // ==========================================================================
  // bit and byte position, cleared while the frame is closed
  always_ff @(posedge sclk_i or negedge reset_n_i or posedge cs_n_i) begin
    if (!reset_n_i || cs_n_i) begin
      phase_q <= '0;
      byte_q  <= '0;
    end else begin
      phase_q <= phase_q + 3'h1;
      if (byte_end && byte_q != BYTE_SAT) begin
        byte_q <= byte_q + 2'h1;
      end
    end
  end

  // ==========================================================================
  // msb first shift; the clock stops outside frames so no clear is needed
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[OP_W-3:0], si_i};
    end
  end

  // ==========================================================================
  // words and their toggles; mid-byte level survives the frame end
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opcode_o   <= OP_RESET;
      op_tog_o   <= TOG_RESET;
      block_o    <= BLOCK_RESET;
      blk_tog_o  <= TOG_RESET;
      mid_byte_o <= FLAG_RESET;
    end else begin
      mid_byte_o <= !byte_end;
      if (byte_end && byte_q == BYTE_OPCODE) begin
        opcode_o <= {shift_q, si_i};
        op_tog_o <= !op_tog_o;
      end
      if (byte_end && byte_q == BYTE_BLOCK) begin
        block_o   <= {shift_q, si_i};
        blk_tog_o <= !blk_tog_o;
      end
    end
  end
endmodule : spi_link_rx

/* File: flash_gate_spi_host.sv */
`timescale 1ns/1ps

// ============================================================================
// spi host model: clock idles low and stands still between frames
module flash_gate_spi_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // n below 8 or off a byte boundary is only sent on purpose
  task automatic xfer(input logic [15:0] data, input int n);
    cs_n_o = 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      si_o = data[15-i];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    #24 cs_n_o = 1'b1;
    // released line: no stale bit left for the device to read
    si_o = ~si_o;
  endtask : xfer
endmodule : flash_gate_spi_host

/* File: flash_suspend_command_gate_asserts.sv */
`timescale 1ns/1ps

// ============================================================================
// port-level checks of the command gate
module flash_gate_checker
  import flash_gate_pkg::*;
(
  input wire logic                               clock_i,
  input wire logic                               reset_n_i,
  input wire logic                               cs_n_i,
  input wire logic                               op_start_i,
  input wire logic                               prog_fault_i,
  input wire logic                               erase_fault_i,
  input wire logic                               cmd_valid_o,
  input wire logic [flash_gate_pkg::OP_W-1:0]    cmd_opcode_o,
  input wire logic                               cmd_reject_o,
  input wire logic                               suspend_req_o,
  input wire logic                               busy_flag_o,
  input wire logic                               write_halted_flag_o,
  input wire logic                               wipe_halted_flag_o,
  input wire logic                               paused_op_flag_o,
  input wire logic                               write_latch_o,
  input wire logic                               write_fault_flag_o,
  input wire logic                               wipe_fault_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_answer;
    cmd_valid_o || cmd_reject_o;
  endsequence
  sequence s_halted;
    !busy_flag_o && (write_halted_flag_o || wipe_halted_flag_o);
  endsequence

  a_answer_exclusive: assert property (!(cmd_valid_o && cmd_reject_o))
    else $error("accept and reject together");
  a_answer_single: assert property (s_answer |=> !(cmd_valid_o || cmd_reject_o))
    else $error("answer longer than one cycle");
  a_answer_after_cs: assert property (s_answer |-> cs_n_i && $past(cs_n_i, 4))
    else $error("answer before chip select release");
  a_suspend_opcode: assert property (suspend_req_o |-> cmd_valid_o &&
    (cmd_opcode_o == OP_SUSPEND_LEGACY || cmd_opcode_o == OP_SUSPEND_NEW))
    else $error("suspend request without suspend opcode");
  a_suspend_not_halted: assert property (suspend_req_o |-> !write_halted_flag_o)
    else $error("suspend accepted during program suspend");
  a_reject_latch_kept: assert property (cmd_reject_o |-> $stable(write_latch_o)[*3])
    else $error("write latch moved on a rejected command");
  a_halt_flags: assert property ($rose(paused_op_flag_o) |-> ##[1:2] s_halted)
    else $error("halt did not clear busy and set halted flag");
  a_busy_on_start: assert property (op_start_i |-> ##2 busy_flag_o)
    else $error("busy not set after start");
  a_write_fault_set: assert property (prog_fault_i |=> write_fault_flag_o)
    else $error("program fault not flagged");
  a_wipe_fault_set: assert property (erase_fault_i |=> wipe_fault_flag_o)
    else $error("erase fault not flagged");
endmodule : flash_gate_checker

/* File: test_flash_suspend_command_gate.sv */
`timescale 1ns/1ps

// ============================================================================
// bench top
module test_flash_suspend_command_gate;
  import flash_gate_pkg::*;

  localparam int LIMIT = 20000;
  logic        clock_i;
  logic        reset_n_i;
  logic [6:0]  ev;
  op_kind_e    op_kind;
  logic [7:0]  op_block;
  wire         sclk_i, cs_n_i, si_i;
  logic        cmd_valid_o, cmd_reject_o, suspend_req_o, busy_flag_o, paused_op_flag_o;
  logic        write_halted_flag_o, wipe_halted_flag_o, write_latch_o;
  logic        write_fault_flag_o, wipe_fault_flag_o;
  logic [7:0]  cmd_opcode_o;
  int          n_fail, n_tests, cyc;
  // column picked by state: bit 10 busy, bit 9 program suspend, bit 8 erase suspend
  logic [11:0] tab [] = '{12'h705, 12'h735, 12'h715, 12'h765, 12'h7F0, 12'h766, 12'h799,
    12'h79F, 12'h790, 12'h794, 12'h7AB, 12'h306, 12'h303, 12'h30B, 12'h33B, 12'h36B,
    12'h3EB, 12'h3E7, 12'h37A, 12'h3D0, 12'h350, 12'h33C, 12'h33D, 12'h34B, 12'h35A,
    12'h377, 12'h102, 12'h1A2, 12'h132, 12'h1AD, 12'h1AF, 12'h020, 12'h052, 12'h0D8,
    12'h060, 12'h0C7, 12'h036, 12'h039, 12'h07E, 12'h098, 12'h09B, 12'h001, 12'h031,
    12'h011, 12'h071, 12'h06F, 12'h0B9, 12'h079, 12'h304};

  initial clock_i = 1'b0;
  always #12.5 clock_i = ~clock_i;

  flash_gate_spi_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));

  flash_suspend_command_gate uut (.clock_i, .reset_n_i, .sclk_i, .cs_n_i, .si_i,
    .op_start_i(ev[0]), .op_kind_i(op_kind), .op_block_i(op_block), .op_done_i(ev[1]),
    .suspend_done_i(ev[2]), .resume_i(ev[3]), .prog_fault_i(ev[4]),
    .erase_fault_i(ev[5]), .fault_clear_i(ev[6]), .cmd_valid_o, .cmd_opcode_o,
    .cmd_reject_o, .suspend_req_o, .busy_flag_o, .write_halted_flag_o,
    .wipe_halted_flag_o, .paused_op_flag_o, .write_latch_o, .write_fault_flag_o,
    .wipe_fault_flag_o);

  // ==========================================================================
  // shared tasks
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic flags(input logic [3:0] e);
    check({4'h0, busy_flag_o, write_halted_flag_o, wipe_halted_flag_o, paused_op_flag_o},
      {4'h0, e});
  endtask : flags

  // answer lands 5..7 cycles after release; 12 also keeps frame spacing
  task automatic listen(output logic [7:0] got);
    got = 8'h00;
    repeat (12) begin
      @(posedge clock_i);
      #1;
      if (cmd_valid_o === 1'b1 || cmd_reject_o === 1'b1)
        got = {5'h0, cmd_valid_o, cmd_reject_o, suspend_req_o};
    end
  endtask : listen

  task automatic frame(input logic [7:0] op, input logic [7:0] blk, input logic v);
    logic [7:0] got;
    logic       wl;
    wl = write_latch_o;
    host.xfer({op, blk}, 16);
    listen(got);
    check(got, {5'h0, v, !v, v && (op == OP_SUSPEND_LEGACY || op == OP_SUSPEND_NEW)});
    check(cmd_opcode_o, op);
    if (!v || op == OP_WRITE_ENABLE || op == OP_WRITE_DISABLE)
      check({7'h0, write_latch_o}, {7'h0, v ? op == OP_WRITE_ENABLE : wl});
  endtask : frame

  task automatic table_run(input int col);
    foreach (tab[i])
      frame(tab[i][7:0], 8'h20, tab[i][8+col]);
  endtask : table_run

  task automatic arr(input int w);
    @(posedge clock_i);
    ev <= 7'h01 << w;
    @(posedge clock_i);
    ev <= 7'h00;
    repeat (3) @(posedge clock_i);
    #1;
  endtask : arr

  task automatic start(input op_kind_e k, input logic [7:0] b);
    @(posedge clock_i);
    op_kind  <= k;
    op_block <= b;
    arr(0);
  endtask : start

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    flags(4'h0);
    check({cmd_valid_o, cmd_reject_o, suspend_req_o, write_latch_o, write_fault_flag_o,
      wipe_fault_flag_o, 2'b00}, 8'h00);
    check(cmd_opcode_o, 8'h00);
  endtask : t_reset

  task automatic t_idle();
    frame(OP_WRITE_ENABLE, 8'h00, 1'b1);
    frame(OP_WRITE_DISABLE, 8'h00, 1'b1);
    frame(OP_SUSPEND_LEGACY, 8'h00, 1'b0);
    frame(OP_WRITE_ENABLE, 8'h00, 1'b1);
  endtask : t_idle

  task automatic t_busy();
    logic [7:0] got;
    start(OPK_PROGRAM, 8'h01);
    flags(4'h8);
    table_run(2);
    host.xfer({OP_SUSPEND_LEGACY, 8'h00}, 4);
    listen(got);
    check(got, 8'h00);
    host.xfer({OP_SUSPEND_LEGACY, 8'h00}, 12);
    listen(got);
    // whole opcode but cut off the byte boundary: answered as a reject
    check(got, 8'h02);
    frame(OP_SUSPEND_LEGACY, 8'h00, 1'b1);
    flags(4'h8);
    arr(2);
    flags(4'h5);
  endtask : t_busy

  task automatic t_prog_paused_op_flag();
    table_run(1);
    frame(OP_SUSPEND_NEW, 8'h00, 1'b0);
    arr(3);
    flags(4'h8);
    arr(1);
    flags(4'h0);
  endtask : t_prog_paused_op_flag

  task automatic t_erase_paused_op_flag();
    start(OPK_ERASE, 8'h05);
    frame(OP_SUSPEND_NEW, 8'h00, 1'b1);
    arr(2);
    flags(4'h3);
    table_run(0);
    frame(8'h02, 8'h05, 1'b0);
    frame(OP_SUSPEND_LEGACY, 8'h00, 1'b0);
    start(OPK_PROGRAM, 8'h06);
    flags(4'hB);
    arr(1);
    flags(4'h3);
    arr(3);
    flags(4'h8);
    arr(1);
    flags(4'h0);
  endtask : t_erase_paused_op_flag

  task automatic t_fixed();
    start(OPK_FIXED, 8'h02);
    frame(OP_SUSPEND_LEGACY, 8'h00, 1'b0);
    arr(1);
    flags(4'h0);
  endtask : t_fixed

  task automatic t_fault();
    arr(4);
    check({6'h0, write_fault_flag_o, wipe_fault_flag_o}, 8'h02);
    arr(5);
    check({6'h0, write_fault_flag_o, wipe_fault_flag_o}, 8'h03);
    @(posedge clock_i);
    ev <= 7'h60;
    @(posedge clock_i);
    ev <= 7'h00;
    repeat (2) @(posedge clock_i);
    #1;
    check({6'h0, write_fault_flag_o, wipe_fault_flag_o}, 8'h01);
    arr(6);
    check({6'h0, write_fault_flag_o, wipe_fault_flag_o}, 8'h00);
  endtask : t_fault

  // ==========================================================================
  // main sequence and hang guard
  initial begin
    reset_n_i = 1'b0;
    ev        = 7'h00;
    op_kind   = OPK_PROGRAM;
    op_block  = 8'h00;
    n_fail    = 0;
    n_tests   = 0;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    t_reset();
    t_idle();
    t_busy();
    t_prog_paused_op_flag();
    t_erase_paused_op_flag();
    t_fixed();
    t_fault();
    end_sim();
  end

  initial cyc = 0;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end
endmodule : test_flash_suspend_command_gate

bind flash_suspend_command_gate flash_gate_checker chk (.clock_i, .reset_n_i, .cs_n_i,
  .op_start_i, .prog_fault_i, .erase_fault_i, .cmd_valid_o, .cmd_opcode_o, .cmd_reject_o,
  .suspend_req_o, .busy_flag_o, .write_halted_flag_o, .wipe_halted_flag_o,
  .paused_op_flag_o, .write_latch_o, .write_fault_flag_o, .wipe_fault_flag_o);
